/* include/hpif_pkg.sv */
// Constants shared by the handwheel pulse input follower
package hpif_pkg;
   // ---------------------------------------------------------------
   // Register word indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_COMMAND = 4'h0;
   localparam logic [3:0] IDX_ENV1 = 4'h1;
   localparam logic [3:0] IDX_ENV2 = 4'h2;
   localparam logic [3:0] IDX_ENV6 = 4'h3;
   localparam logic [3:0] IDX_START_SPEED = 4'h4;
   localparam logic [3:0] IDX_HIGH_SPEED = 4'h5;
   localparam logic [3:0] IDX_STATUS = 4'h6;
   localparam logic [3:0] IDX_ERROR = 4'h7;
   localparam logic [3:0] IDX_BUFFER = 4'h8;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ENV1_FILTER_BIT = 27;
   localparam int ENV2_DISABLE_BIT = 31;
   localparam int ENV2_METHOD_LSB = 24;
   localparam int ENV2_COUNT_DIR_BIT = 26;
   localparam int ENV6_MULT_LSB = 0;
   localparam int ENV6_DIV_LSB = 8;
   localparam int ERR_PHASE_BIT = 17;
   localparam int ERR_OVERFLOW_BIT = 14;
   localparam int STAT_RUN_BIT = 4;
   localparam int STAT_DIR_BIT = 5;
   localparam int DIV_SHIFT = 11;
   // ---------------------------------------------------------------
   // Commands, codes and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_START_SPEED_CONST = 8'h50;
   localparam logic [7:0] CMD_HIGH_SPEED_CONST = 8'h51;
   localparam logic [7:0] CMD_IMMEDIATE_STOP = 8'h49;
   localparam logic [3:0] COND_IDLE = 4'h0;
   localparam logic [3:0] COND_WAIT_PULSER = 4'h8;
   localparam logic [1:0] METHOD_QUAD_1X = 2'h0;
   localparam logic [1:0] METHOD_QUAD_2X = 2'h1;
   localparam logic [1:0] METHOD_QUAD_4X = 2'h2;
   localparam logic [1:0] METHOD_UP_DOWN = 2'h3;
   localparam logic [31:0] ENV_RESET = 32'h0000_0000;
   localparam logic [15:0] SPEED_RESET = 16'h0064;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FILTER_TIME_MS = 32;
   localparam int FILTER_CYCLES = (FILTER_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* verilog/hpif_decoder.sv */
// Phase input decoder: quadrature 1x/2x/4x or separate up and down trains
`timescale 1ns/1ps
module hpif_decoder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Synchronised phases and settings
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic [1:0] method,
   input wire logic count_dir,
   // Decoded events
   output logic decoded_up_count,
   output logic decoded_down_count,
   output logic phase_error
);
   logic prev_a_ff;
   logic prev_b_ff;
   logic up_ff;
   logic down_ff;
   logic err_ff;
   wire chg_a = phase_a ^ prev_a_ff;
   wire chg_b = phase_b ^ prev_b_ff;
   wire both_chg = chg_a & chg_b;
   // A leads B when the new A differs from the old B
   wire a_leads = phase_a ^ prev_b_ff;
   wire quad_fwd = a_leads ^ count_dir;
   wire rise_a = chg_a & phase_a & ~chg_b;
   wire rise_b = chg_b & phase_b & ~chg_a;
   wire quad_edge = (method == hpif_pkg::METHOD_QUAD_1X) ? rise_a :
                    (method == hpif_pkg::METHOD_QUAD_2X) ? (chg_a & ~chg_b) :
                    ((chg_a | chg_b) & ~both_chg);
   wire pulse_mode = (method == hpif_pkg::METHOD_UP_DOWN);
   wire nxt_up = pulse_mode ? (count_dir ? rise_b : rise_a) : (quad_edge & quad_fwd);
   wire nxt_down = pulse_mode ? (count_dir ? rise_a : rise_b) : (quad_edge & ~quad_fwd);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prev_a_ff <= 1'b0;
         prev_b_ff <= 1'b0;
         up_ff <= 1'b0;
         down_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         prev_a_ff <= phase_a;
         prev_b_ff <= phase_b;
         up_ff <= nxt_up;
         down_ff <= nxt_down;
         err_ff <= both_chg;
      end
   end

   assign decoded_up_count = up_ff;
   assign decoded_down_count = down_ff;
   assign phase_error = err_ff;
endmodule

/* verilog/hpif_scaler.sv */
// Count scaler: 1x..32x multiplier followed by an n/2048 divider
`timescale 1ns/1ps
module hpif_scaler (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clear,
   // Decoded events and settings
   input wire logic event_up,
   input wire logic event_down,
   input wire logic [4:0] mult_field,
   input wire logic [10:0] div_field,
   // Signed count change, one cycle per event
   output logic signed [6:0] delta
);
   logic signed [18:0] acc_ff;
   logic signed [6:0] delta_ff;
   // Fraction kept between events so the divider loses no counts
   wire [5:0] factor = {1'b0, mult_field} + 6'h01;
   wire [11:0] div_n = (div_field == 11'h000) ? 12'h800 : {1'b0, div_field};
   wire [17:0] weight = {12'h000, factor} * {6'h00, div_n};
   wire signed [18:0] add_w = event_up ? $signed({1'b0, weight}) :
                              event_down ? -$signed({1'b0, weight}) : 19'sh0;
   wire signed [18:0] nxt_acc = acc_ff + add_w;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         acc_ff <= 19'sh0;
         delta_ff <= 7'sh0;
      end else if (clear) begin
         acc_ff <= 19'sh0;
         delta_ff <= 7'sh0;
      end else begin
         acc_ff <= $signed({8'h00, nxt_acc[10:0]});
         delta_ff <= $signed(nxt_acc[17:11]);
      end
   end

   assign delta = delta_ff;
endmodule

/* verilog/hpif_top.sv */
// Handwheel pulse input follower with Avalon-MM register slave
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module hpif_top #(
   parameter int FILTER_CYCLES = hpif_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Pulser and machine inputs
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   input wire logic pulser_enable_n,
   input wire logic [1:0] manual_direction_input,
   input wire logic [1:0] end_limit_input,
   // Motor and status outputs
   output logic pulse_out,
   output logic dir_out,
   output logic [1:0] manual_direction_filtered,
   output logic error_irq
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int NSYNC = 7;
   localparam int NFILT = 3;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;
   logic [NFILT-1:0] filt_ff;
   logic ack_ff;
   logic [31:0] readdata_ff;
   logic [31:0] env1_ff;
   logic [31:0] env2_ff;
   logic [31:0] env6_ff;
   logic [15:0] start_speed_ff;
   logic [15:0] high_speed_ff;
   logic running_ff;
   logic speed_sel_ff;
   logic [15:0] tick_cnt_ff;
   logic signed [15:0] buf_cnt_ff;
   logic [22:0] gap_ff;
   logic err_phase_ff;
   logic err_ovf_ff;
   logic pulse_ff;
   logic dir_ff;
   logic dec_up;
   logic dec_down;
   logic dec_err;
   logic signed [6:0] delta;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Bit order: a, b, enable_n, dr0, dr1, limit plus, limit minus
   wire [NSYNC-1:0] raw_in = {end_limit_input, manual_direction_input, pulser_enable_n,
                              phase_b_input, phase_a_input};
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_ff <= 7'h04;
         sync_ff <= 7'h04;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end
   wire sync_a = sync_ff[0];
   wire sync_b = sync_ff[1];
   wire limit_pos = sync_ff[5];
   wire limit_neg = sync_ff[6];

   // ---------------------------------------------------------------
   // Direction and enable filter
   // ---------------------------------------------------------------
   // With ENV1 bit 27 set, a change passes only after it has held for the whole filter time; with it clear, at once
   wire filter_on = env1_ff[hpif_pkg::ENV1_FILTER_BIT];
   genvar gi;
   generate
      for (gi = 0; gi < NFILT; gi++) begin : g_filt
         logic [21:0] cnt_ff;
         wire raw = sync_ff[gi + 2];
         wire differs = raw ^ filt_ff[gi];
         wire held = (cnt_ff >= 22'(FILTER_CYCLES - 1));
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               cnt_ff <= 22'h000000;
               filt_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
            end else if (!differs) begin
               cnt_ff <= 22'h000000;
            end else if (!filter_on || held) begin
               cnt_ff <= 22'h000000;
               filt_ff[gi] <= raw;
            end else begin
               cnt_ff <= cnt_ff + 22'h000001;
            end
         end
      end
   endgenerate
   wire pe_n_filt = filt_ff[0];
   assign manual_direction_filtered = filt_ff[2:1];

   // ---------------------------------------------------------------
   // Avalon-MM register access
   // ---------------------------------------------------------------
   // One wait state: the readback is registered before waitrequest drops
   wire req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_ff;
   wire wr_en = avs_write & ~avs_waitrequest;
   wire wr_cmd = wr_en & (avs_address == hpif_pkg::IDX_COMMAND) & avs_byteenable[0];
   wire wr_env1 = wr_en & (avs_address == hpif_pkg::IDX_ENV1);
   wire wr_env2 = wr_en & (avs_address == hpif_pkg::IDX_ENV2);
   wire wr_env6 = wr_en & (avs_address == hpif_pkg::IDX_ENV6);
   wire wr_fl = wr_en & (avs_address == hpif_pkg::IDX_START_SPEED);
   wire wr_fh = wr_en & (avs_address == hpif_pkg::IDX_HIGH_SPEED);
   wire wr_err = wr_en & (avs_address == hpif_pkg::IDX_ERROR);
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wr_bits = avs_writedata & be_mask;
   wire [7:0] cmd_code = avs_writedata[7:0];
   wire cmd_start_fl = wr_cmd & (cmd_code == hpif_pkg::CMD_START_SPEED_CONST);
   wire cmd_start_fh = wr_cmd & (cmd_code == hpif_pkg::CMD_HIGH_SPEED_CONST);
   wire cmd_stop = wr_cmd & (cmd_code == hpif_pkg::CMD_IMMEDIATE_STOP);

   wire [3:0] cond = running_ff ? hpif_pkg::COND_WAIT_PULSER : hpif_pkg::COND_IDLE;
   wire [31:0] status_word = {26'h0000000, dir_ff, running_ff, cond} |
                             (32'(speed_sel_ff) << (hpif_pkg::STAT_DIR_BIT + 1));
   wire [31:0] error_word = (32'(err_phase_ff) << hpif_pkg::ERR_PHASE_BIT) |
                            (32'(err_ovf_ff) << hpif_pkg::ERR_OVERFLOW_BIT);
   wire [31:0] rd_mux = (avs_address == hpif_pkg::IDX_ENV1) ? env1_ff :
                        (avs_address == hpif_pkg::IDX_ENV2) ? env2_ff :
                        (avs_address == hpif_pkg::IDX_ENV6) ? env6_ff :
                        (avs_address == hpif_pkg::IDX_START_SPEED) ? {16'h0000, start_speed_ff} :
                        (avs_address == hpif_pkg::IDX_HIGH_SPEED) ? {16'h0000, high_speed_ff} :
                        (avs_address == hpif_pkg::IDX_STATUS) ? status_word :
                        (avs_address == hpif_pkg::IDX_ERROR) ? error_word :
                        (avs_address == hpif_pkg::IDX_BUFFER) ? 32'(buf_cnt_ff) : 32'h0000_0000;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ack_ff <= 1'b0;
         readdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req & ~ack_ff;
         readdata_ff <= rd_mux;
      end
   end
   assign avs_readdata = readdata_ff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         env1_ff <= hpif_pkg::ENV_RESET;
         env2_ff <= hpif_pkg::ENV_RESET;
         env6_ff <= hpif_pkg::ENV_RESET;
         start_speed_ff <= hpif_pkg::SPEED_RESET;
         high_speed_ff <= hpif_pkg::SPEED_RESET;
      end else begin
         if (wr_env1) env1_ff <= (env1_ff & ~be_mask) | wr_bits;
         if (wr_env2) env2_ff <= (env2_ff & ~be_mask) | wr_bits;
         if (wr_env6) env6_ff <= (env6_ff & ~be_mask) | wr_bits;
         if (wr_fl) start_speed_ff <= (start_speed_ff & ~be_mask[15:0]) | wr_bits[15:0];
         if (wr_fh) high_speed_ff <= (high_speed_ff & ~be_mask[15:0]) | wr_bits[15:0];
      end
   end

   // ---------------------------------------------------------------
   // Settings
   // ---------------------------------------------------------------
   wire [1:0] method = env2_ff[hpif_pkg::ENV2_METHOD_LSB +: 2];
   wire count_dir = env2_ff[hpif_pkg::ENV2_COUNT_DIR_BIT];
   wire inputs_off = env2_ff[hpif_pkg::ENV2_DISABLE_BIT];
   wire [4:0] mult_field = env6_ff[hpif_pkg::ENV6_MULT_LSB +: 5];
   wire [10:0] div_field = env6_ff[hpif_pkg::ENV6_DIV_LSB +: 11];
   // A zero period would stall the stream, so it is treated as one
   wire [15:0] period_raw = speed_sel_ff ? high_speed_ff : start_speed_ff;
   wire [15:0] period = (period_raw == 16'h0000) ? 16'h0001 : period_raw;

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         running_ff <= 1'b0;
         speed_sel_ff <= 1'b0;
      end else if (cmd_stop) begin
         running_ff <= 1'b0;
      end else if (cmd_start_fl | cmd_start_fh) begin
         running_ff <= 1'b1;
         speed_sel_ff <= cmd_start_fh;
      end
   end

   // ---------------------------------------------------------------
   // Decode and scale
   // ---------------------------------------------------------------
   hpif_decoder u_decoder (
      .ref_clk(ref_clk),
      .reset(reset),
      .phase_a(sync_a),
      .phase_b(sync_b),
      .method(method),
      .count_dir(count_dir),
      .decoded_up_count(dec_up),
      .decoded_down_count(dec_down),
      .phase_error(dec_err)
   );

   wire accept = running_ff & ~pe_n_filt & ~inputs_off;
   // Counts toward an active limit are dropped; the other way still runs
   wire acc_up = accept & dec_up & ~limit_pos;
   wire acc_down = accept & dec_down & ~limit_neg;

   hpif_scaler u_scaler (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(~running_ff),
      .event_up(acc_up),
      .event_down(acc_down),
      .mult_field(mult_field),
      .div_field(div_field),
      .delta(delta)
   );

   // ---------------------------------------------------------------
   // Input rate check
   // ---------------------------------------------------------------
   // Least spacing of decoded counts is period x factor x n/2048
   wire [5:0] factor = {1'b0, mult_field} + 6'h01;
   wire [11:0] div_n = (div_field == 11'h000) ? 12'h800 : {1'b0, div_field};
   wire [33:0] min_prod = {18'h00000, period} * {28'h0000000, factor} * {22'h000000, div_n};
   wire [22:0] min_gap = min_prod[hpif_pkg::DIV_SHIFT +: 23];
   wire too_fast = (acc_up | acc_down) & (gap_ff < min_gap);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gap_ff <= '1;
      end else if (!running_ff || acc_up || acc_down) begin
         gap_ff <= running_ff ? 23'h000000 : '1;
      end else if (gap_ff != '1) begin
         gap_ff <= gap_ff + 23'h000001;
      end
   end

   // ---------------------------------------------------------------
   // Speed stream and output gating
   // ---------------------------------------------------------------
   wire tick = running_ff & (tick_cnt_ff >= period - 16'h0001);
   wire buf_pos = ~buf_cnt_ff[15] & (buf_cnt_ff != 16'sh0000);
   wire buf_neg = buf_cnt_ff[15];
   wire emit = tick & (buf_pos | buf_neg);
   wire signed [16:0] step = emit ? (buf_pos ? 17'sh00001 : -17'sh00001) : 17'sh00000;
   wire signed [16:0] sum = {buf_cnt_ff[15], buf_cnt_ff} + {{10{delta[6]}}, delta} - step;
   wire ovf_hi = ~sum[16] & sum[15];
   wire ovf_lo = sum[16] & ~sum[15];
   wire overflow = running_ff & (ovf_hi | ovf_lo);
   wire limit_hit = (buf_pos & limit_pos) | (buf_neg & limit_neg);
   wire signed [15:0] nxt_buf = ovf_hi ? 16'sh7fff : ovf_lo ? -16'sh8000 : sum[15:0];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tick_cnt_ff <= 16'h0000;
         buf_cnt_ff <= 16'sh0000;
         pulse_ff <= 1'b0;
         dir_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= (tick || !running_ff) ? 16'h0000 : tick_cnt_ff + 16'h0001;
         buf_cnt_ff <= (!running_ff || limit_hit) ? 16'sh0000 : nxt_buf;
         pulse_ff <= emit & ~limit_hit;
         // A pulse swallowed by a limit must not move the direction either
         if (emit & ~limit_hit) dir_ff <= buf_pos;
      end
   end
   assign pulse_out = pulse_ff;
   assign dir_out = dir_ff;

   // ---------------------------------------------------------------
   // Error cause
   // ---------------------------------------------------------------
   // Write one to clear; a new error in the same cycle wins over the clear
   wire set_phase = (accept & dec_err) | too_fast;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         err_phase_ff <= 1'b0;
         err_ovf_ff <= 1'b0;
      end else begin
         err_phase_ff <= set_phase | (err_phase_ff & ~(wr_err & wr_bits[hpif_pkg::ERR_PHASE_BIT]));
         err_ovf_ff <= overflow | (err_ovf_ff & ~(wr_err & wr_bits[hpif_pkg::ERR_OVERFLOW_BIT]));
      end
   end
   assign error_irq = err_phase_ff | err_ovf_ff;
endmodule

/* test/hpif_checker_sva.sv */
// Concurrent checks on the follower's register bus and motor outputs
`timescale 1ns/1ps
module hpif_checker #(
   parameter int FILTER_CYCLES = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Motor outputs
   input wire logic pulse_out,
   input wire logic dir_out,
   input wire logic error_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire wr_take = avs_write && !avs_waitrequest;
   wire rd_take = avs_read && !avs_waitrequest;
   wire cmd_wr = wr_take && avs_address == hpif_pkg::IDX_COMMAND;
   // Set by 50h or 51h; never cleared, so it only guards the time before the first start
   logic armed_ff;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         armed_ff <= 1'b0;
      else if (cmd_wr && avs_writedata[7:1] == 7'h28)
         armed_ff <= 1'b1;
   end
   property p_wait_one; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   property p_no_wait; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
   property p_unmapped; rd_take && avs_address > hpif_pkg::IDX_BUFFER |-> avs_readdata == 32'h0; endproperty
   property p_cond;
      rd_take && avs_address == hpif_pkg::IDX_STATUS |-> avs_readdata[3:0] == (avs_readdata[4] ? 4'h8 : 4'h0);
   endproperty
   property p_irq;
      rd_take && avs_address == hpif_pkg::IDX_ERROR |-> $past(error_irq) == (avs_readdata[17] || avs_readdata[14]);
   endproperty
   property p_idle; !armed_ff |-> !pulse_out; endproperty
   property p_stop; cmd_wr && avs_writedata[7:0] == 8'h49 |-> ##2 !pulse_out [*8]; endproperty
   property p_pulse; pulse_out |=> !pulse_out; endproperty
   property p_dir; $changed(dir_out) |-> pulse_out; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle");
   a_no_wait: assert property (p_no_wait) else $error("waitrequest without request");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_cond: assert property (p_cond) else $error("condition code wrong");
   a_irq: assert property (p_irq) else $error("irq disagrees with error flags");
   a_idle: assert property (p_idle) else $error("pulse before start");
   a_stop: assert property (p_stop) else $error("pulse after stop");
   a_pulse: assert property (p_pulse) else $error("pulse longer than a cycle");
   a_dir: assert property (p_dir) else $error("direction moved without pulse");
   c_start: cover property (cmd_wr && avs_writedata[7:0] == 8'h50);
   c_back: cover property (pulse_out && !dir_out);
   c_err: cover property (error_irq);
endmodule
bind hpif_top hpif_checker #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (.ref_clk(ref_clk), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pulse_out(pulse_out),
   .dir_out(dir_out), .error_irq(error_irq));

/* test/hpif_pulser_model.sv */
// Manual pulse generator model driving the two phase lines
`timescale 1ns/1ps
module hpif_pulser_model (
   // Clock
   input wire logic ref_clk,
   // Phase lines
   output logic phase_a,
   output logic phase_b
);
   // Wide spacing keeps the rate under the scaled speed limit; never reverses mid-move
   localparam int GAP = 30;
   int pos = 0;
   initial begin
      phase_a = 1'b0;
      phase_b = 1'b0;
   end
   task automatic step(input bit fwd);
      pos = (fwd ? pos + 1 : pos + 3) % 4;
      phase_a <= (pos == 1 || pos == 2);
      phase_b <= (pos >= 2);
      repeat (GAP) @(posedge ref_clk);
   endtask
   // Whole cycles only, so the lines end where they began
   task automatic turn(input int cycles, input bit fwd, input bit train);
      for (int i = 0; i < cycles; i++) begin
         if (train) begin
            if (fwd) phase_a <= 1'b1; else phase_b <= 1'b1;
            repeat (GAP) @(posedge ref_clk);
            phase_a <= 1'b0;
            phase_b <= 1'b0;
            repeat (GAP) @(posedge ref_clk);
         end else
            repeat (4) step(fwd);
      end
   endtask
   // Both lines flip together, twice
   task automatic glitch();
      repeat (2) begin
         phase_a <= !phase_a;
         phase_b <= !phase_b;
         repeat (GAP) @(posedge ref_clk);
      end
   endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the handwheel pulse input follower
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, pa, pb, pulse_out, dir_out, error_irq;
   logic pe_n = 1'b0;
   logic [1:0] lim = 2'h0;
   logic [1:0] mdi = 2'h0;
   logic [1:0] mdf;
   logic [31:0] q;
   int failures = 0;
   int check_count = 0;
   int up_n = 0;
   int dn_n = 0;
   always #5 ref_clk = ~ref_clk;
   hpif_top #(.FILTER_CYCLES(8)) u_dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phase_a_input(pa),
      .phase_b_input(pb), .pulser_enable_n(pe_n), .manual_direction_input(mdi), .end_limit_input(lim),
      .pulse_out(pulse_out), .dir_out(dir_out), .manual_direction_filtered(mdf), .error_irq(error_irq));
   hpif_pulser_model u_pulser (.ref_clk(ref_clk), .phase_a(pa), .phase_b(pb));
   always @(posedge ref_clk) begin
      if (pulse_out === 1'b1) begin
         if (dir_out === 1'b1) up_n++; else dn_n++;
      end
   end
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge ref_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 50) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b0, a, d, r);
   endtask
   // Turn the pulser, let the output catch up, then tally both directions
   task automatic run(input int cyc, input bit fwd, input bit train, input int eu, input int ed);
      int i;
      up_n = 0;
      dn_n = 0;
      u_pulser.turn(cyc, fwd, train);
      for (i = 0; i < 400 && up_n + dn_n < eu + ed; i++) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
      check("up pulses", 32'(eu), 32'(up_n));
      check("down pulses", 32'(ed), 32'(dn_n));
   endtask
   task automatic t_regs();
      bus(1'b1, hpif_pkg::IDX_ENV2, 32'h0, q);
      check("env2", 32'h0, q);
      bus(1'b1, hpif_pkg::IDX_START_SPEED, 32'h0, q);
      check("start speed", 32'h64, q);
      bus(1'b1, 4'h9, 32'h0, q);
      check("unmapped", 32'h0, q);
      run(1, 1'b1, 1'b0, 0, 0);
      $display("test regs done");
   endtask
   task automatic t_modes();
      wr(hpif_pkg::IDX_START_SPEED, 32'h2);
      wr(hpif_pkg::IDX_COMMAND, 32'h50);
      bus(1'b1, hpif_pkg::IDX_STATUS, 32'h0, q);
      check("condition", 32'h8, {28'h0, q[3:0]});
      for (int m = 0; m < 4; m++) begin
         wr(hpif_pkg::IDX_ENV2, 32'(m) << 24);
         run(2, 1'b1, m == 3, (m == 2) ? 8 : (m == 1) ? 4 : 2, 0);
      end
      $display("test modes done");
   endtask
   task automatic t_scale();
      wr(hpif_pkg::IDX_ENV2, 32'h0600_0000);
      wr(hpif_pkg::IDX_ENV6, 32'h0004_0002);
      run(1, 1'b1, 1'b0, 0, 6);
      run(1, 1'b0, 1'b0, 6, 0);
      wr(hpif_pkg::IDX_ENV6, 32'h0);
      $display("test scale done");
   endtask
   task automatic t_err();
      u_pulser.glitch();
      bus(1'b1, hpif_pkg::IDX_ERROR, 32'h0, q);
      check("phase error", 32'h0002_0000, q & 32'h0002_0000);
      check("irq", 32'h1, {31'h0, error_irq});
      wr(hpif_pkg::IDX_ERROR, 32'h0002_0000);
      bus(1'b1, hpif_pkg::IDX_ERROR, 32'h0, q);
      check("cleared", 32'h0, q & 32'h0002_0000);
      $display("test error done");
   endtask
   task automatic t_gate();
      wr(hpif_pkg::IDX_ENV2, 32'h8200_0000);
      run(1, 1'b1, 1'b0, 0, 0);
      wr(hpif_pkg::IDX_ENV2, 32'h0200_0000);
      pe_n <= 1'b1;
      run(1, 1'b1, 1'b0, 0, 0);
      pe_n <= 1'b0;
      run(1, 1'b1, 1'b0, 4, 0);
      $display("test gate done");
   endtask
   // Plus limit drops forward counts without error; a direction change is held back until it has lasted the filter time
   task automatic t_io();
      lim <= 2'h1;
      run(1, 1'b1, 1'b0, 0, 0);
      run(1, 1'b0, 1'b0, 0, 4);
      check("limit irq", 32'h0, {31'h0, error_irq});
      lim <= 2'h0;
      wr(hpif_pkg::IDX_ENV1, 32'h0800_0000);
      mdi <= 2'h3;
      repeat (4) @(posedge ref_clk);
      check("dir early", 32'h0, {30'h0, mdf});
      repeat (10) @(posedge ref_clk);
      check("dir held", 32'h3, {30'h0, mdf});
      mdi <= 2'h0;
      $display("test io done");
   endtask
   task automatic t_stop();
      wr(hpif_pkg::IDX_COMMAND, 32'h49);
      bus(1'b1, hpif_pkg::IDX_STATUS, 32'h0, q);
      check("condition", 32'h0, {28'h0, q[3:0]});
      run(1, 1'b1, 1'b0, 0, 0);
      $display("test stop done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs();
      t_modes();
      t_scale();
      t_err();
      t_gate();
      t_io();
      t_stop();
      stop_test();
   end
endmodule
